// ### src/ddc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ddc_pin_sync
  import ddc_pkg::*;
(
  input  wire logic      clk_sys, // system clock
  input  wire logic      rst_n,   // synchronous reset, low
  input  wire ddc_pins_t pin_i,   // raw pins
  output ddc_pins_t      pin_o    // filtered pins
);
  localparam ddc_pins_t IDLE_LVL = 3'h7;
  ddc_pins_t s1_ff, s2_ff, s3_ff, out_ff;

  assign pin_o = out_ff;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          s1_ff[i]  <= IDLE_LVL[i];
          s2_ff[i]  <= IDLE_LVL[i];
          s3_ff[i]  <= IDLE_LVL[i];
          out_ff[i] <= IDLE_LVL[i];
        end else begin
          s1_ff[i] <= pin_i[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          // a change counts only once two stages agree
          if (s2_ff[i] == s3_ff[i]) begin
            out_ff[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate
endmodule

// ### src/ddc_pkg.sv
// shared constants and types for the dual converter command decoder
package ddc_pkg;
  localparam int          VAL_W        = 10;
  // apb register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_DAC_A    = 8'h04;
  localparam logic [7:0]  OFS_DAC_B    = 8'h08;
  localparam logic [7:0]  OFS_INPUT    = 8'h0c;
  localparam logic [7:0]  OFS_STAT     = 8'h10;
  // field positions
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CHAN_PD_LSB  = 12;
  localparam int          INP_B_LSB    = 16;
  localparam int          EXT_SEL_A    = 0;
  localparam int          EXT_SEL_B    = 1;
  localparam int          EXT_PD_LSB   = 6;
  localparam int          STAT_EXT     = 0;
  localparam int          STAT_RDSEL   = 1;
  localparam int          STAT_IDLE    = 2;
  localparam int          STAT_STRAP   = 3;
  // reset values
  localparam logic [9:0]  RST_CODE     = 10'h000;
  localparam logic [1:0]  RST_PD       = 2'h3;
  localparam logic        RST_CTRL_EN  = 1'b1;
  // cycles counted after reset before the strap is caught, one fewer than pin_s needs to settle
  localparam logic [1:0]  STRAP_SETTLE = 2'h3;
  // command codes
  localparam logic [3:0]  CMD_LD_A     = 4'h0;
  localparam logic [3:0]  CMD_LD_B     = 4'h1;
  localparam logic [3:0]  CMD_IN_A     = 4'h4;
  localparam logic [3:0]  CMD_IN_B     = 4'h5;
  localparam logic [3:0]  CMD_UPD_IN_A = 4'h8;
  localparam logic [3:0]  CMD_UPD_IN_B = 4'h9;
  localparam logic [3:0]  CMD_LD_ALL   = 4'hc;
  localparam logic [3:0]  CMD_IN_ALL   = 4'hd;
  localparam logic [3:0]  CMD_UPD      = 4'he;
  localparam logic [3:0]  CMD_EXT      = 4'hf;
  localparam logic [3:0]  SUB_EXT      = 4'h0;
  localparam logic [3:0]  SUB_RD_A     = 4'h1;
  localparam logic [3:0]  SUB_RD_B     = 4'h2;
  // power-down settings
  localparam logic [1:0]  PD_UP        = 2'h0;
  localparam logic [1:0]  PD_FLOAT     = 2'h1;
  localparam logic [1:0]  PD_LOW_R     = 2'h2;
  localparam logic [1:0]  PD_HIGH_R    = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_SACK = 6'h04,
    ST_WRX  = 6'h08,
    ST_TX   = 6'h10,
    ST_MACK = 6'h20
  } ddc_state_t;

  typedef struct packed {
    logic [1:0] pd;
    logic [9:0] code;
  } ddc_chan_t;

  typedef struct packed {
    logic strap;
    logic scl;
    logic sda;
  } ddc_pins_t;
endpackage

// ### src/ddc_top.sv
// two-wire slave command decoder for a dual 10-bit converter
`timescale 1ns/100ps
module ddc_top
  import ddc_pkg::*;
#(
  parameter logic [5:0] ADDR_UPPER = 6'h2a // arbitrary value
)(
  input  wire logic        clk_sys,    // system clock, 20 MHz
  input  wire logic        rst_n,      // synchronous reset, low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb enable
  input  wire logic        pwrite,     // apb direction
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error
  input  wire logic        scl_i,      // serial clock pin
  input  wire logic        sda_i,      // serial data pin level
  output logic             sda_o,      // serial data drive value
  output logic             sda_oe,     // serial data pull-low enable
  input  wire logic        addr_strap, // address strap pin
  output ddc_chan_t        dac_a,      // converter a state
  output ddc_chan_t        dac_b       // converter b state
);
  ddc_pins_t  pin_s, pin_d_ff;
  ddc_state_t st_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] sh_ff, cmd_ff, data_ff, tx_sh_ff;
  logic       got8_ff, rw_ff, addr_ph_ff, byte_idx_ff, word_end_ff;
  logic       tx_idx_ff, mack_ok_ff, sda_oe_ff, sda_o_ff;
  logic       ext_ff, rd_sel_ff, ctrl_en_ff;
  logic       strap_ff, strap_ld_ff;
  logic [1:0] strap_cnt_ff;
  logic [9:0] in_a_ff, in_b_ff;
  ddc_chan_t  dac_a_ff, dac_b_ff;
  logic [31:0] prdata_ff;
  logic       pready_ff, pslverr_ff;
  logic       scl_rise, scl_fall, start_ev, stop_ev, en, commit;
  logic [6:0] my_addr;
  logic [9:0] new_val, rb_val;
  logic [3:0] cmd_code;

  // read-back byte in the same bit places as a write word
  function automatic logic [7:0] rb_byte(input logic [9:0] v,
                                         input logic       second);
    rb_byte = second ? {v[5:0], 2'h0} : {4'h0, v[9:6]};
  endfunction

  ddc_pin_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_i   ({addr_strap, scl_i, sda_i}),
    .pin_o   (pin_s)
  );

  assign scl_rise = pin_s.scl & ~pin_d_ff.scl;
  assign scl_fall = ~pin_s.scl & pin_d_ff.scl;
  assign start_ev = pin_d_ff.sda & ~pin_s.sda & pin_s.scl & pin_d_ff.scl;
  assign stop_ev  = ~pin_d_ff.sda & pin_s.sda & pin_s.scl & pin_d_ff.scl;
  assign en       = ctrl_en_ff & strap_ld_ff;
  assign my_addr  = {ADDR_UPPER, strap_ff};
  assign cmd_code = cmd_ff[7:4];
  // pad bits data_ff[1:0] are not checked
  assign new_val  = {cmd_ff[3:0], data_ff[7:2]};
  assign rb_val   = rd_sel_ff ? dac_b_ff.code : dac_a_ff.code;
  assign commit   = en && st_ff == ST_SACK && scl_fall && word_end_ff &&
                    !addr_ph_ff;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign sda_o   = sda_o_ff;
  assign sda_oe  = sda_oe_ff;
  assign dac_a   = dac_a_ff;
  assign dac_b   = dac_b_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_d_ff <= 3'h7;
      sda_o_ff <= 1'b0;
    end else begin
      pin_d_ff <= pin_s;
      sda_o_ff <= 1'b0;
    end
  end

  // strap caught four clocks after reset, before pin_s has settled, so it reads the reset level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap_ff     <= 1'b0;
      strap_ld_ff  <= 1'b0;
      strap_cnt_ff <= 2'h0;
    end else if (!strap_ld_ff) begin
      if (strap_cnt_ff == STRAP_SETTLE) begin
        strap_ff    <= pin_s.strap;
        strap_ld_ff <= 1'b1;
      end else begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end

  // serial protocol engine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff       <= ST_IDLE;
      bit_cnt_ff  <= 3'h0;
      sh_ff       <= 8'h00;
      cmd_ff      <= 8'h00;
      data_ff     <= 8'h00;
      tx_sh_ff    <= 8'h00;
      got8_ff     <= 1'b0;
      rw_ff       <= 1'b0;
      addr_ph_ff  <= 1'b0;
      byte_idx_ff <= 1'b0;
      word_end_ff <= 1'b0;
      tx_idx_ff   <= 1'b0;
      mack_ok_ff  <= 1'b0;
      sda_oe_ff   <= 1'b0;
    end else if (!en || stop_ev) begin
      st_ff     <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (start_ev) begin
      // a half-received word is dropped here, nothing was committed
      st_ff       <= ST_ADDR;
      bit_cnt_ff  <= 3'h0;
      got8_ff     <= 1'b0;
      byte_idx_ff <= 1'b0;
      word_end_ff <= 1'b0;
      sda_oe_ff   <= 1'b0;
    end else begin
      case (st_ff)
        ST_ADDR, ST_WRX: begin
          if (scl_rise) begin
            sh_ff      <= {sh_ff[6:0], pin_s.sda};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            got8_ff    <= (bit_cnt_ff == 3'h7);
            // bitwise compare lets the port go quiet early
            if (st_ff == ST_ADDR && bit_cnt_ff != 3'h7 &&
                pin_s.sda != my_addr[3'h6 - bit_cnt_ff]) begin
              st_ff <= ST_IDLE;
            end
          end else if (scl_fall && got8_ff) begin
            got8_ff   <= 1'b0;
            st_ff     <= ST_SACK;
            sda_oe_ff <= 1'b1;
            if (st_ff == ST_ADDR) begin
              rw_ff      <= sh_ff[0];
              addr_ph_ff <= 1'b1;
            end else begin
              addr_ph_ff <= 1'b0;
              if (!byte_idx_ff) begin
                cmd_ff <= sh_ff;
                // update-only word carries no data byte
                word_end_ff <= (sh_ff[7:4] == CMD_UPD);
                byte_idx_ff <= (sh_ff[7:4] != CMD_UPD);
              end else begin
                data_ff     <= sh_ff;
                word_end_ff <= 1'b1;
                byte_idx_ff <= 1'b0;
              end
            end
          end
        end
        ST_SACK: begin
          if (scl_fall) begin
            word_end_ff <= 1'b0;
            bit_cnt_ff  <= 3'h0;
            if (addr_ph_ff && rw_ff) begin
              st_ff     <= ST_TX;
              tx_idx_ff <= 1'b0;
              tx_sh_ff  <= rb_byte(rb_val, 1'b0);
              sda_oe_ff <= ~rb_byte(rb_val, 1'b0)>>7 == 8'h01;
            end else begin
              st_ff     <= ST_WRX;
              sda_oe_ff <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              sda_oe_ff <= 1'b0;
              st_ff     <= ST_MACK;
            end else begin
              tx_sh_ff  <= {tx_sh_ff[6:0], 1'b0};
              sda_oe_ff <= ~tx_sh_ff[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (!pin_s.sda && !tx_idx_ff) begin
              tx_idx_ff  <= 1'b1;
              tx_sh_ff   <= rb_byte(rb_val, 1'b1);
              mack_ok_ff <= 1'b1;
            end else begin
              st_ff <= ST_IDLE;
            end
          end else if (scl_fall && mack_ok_ff) begin
            mack_ok_ff <= 1'b0;
            bit_cnt_ff <= 3'h0;
            st_ff      <= ST_TX;
            sda_oe_ff  <= ~tx_sh_ff[7];
          end
        end
        ST_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        default: begin
          st_ff     <= ST_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // converter registers, written only at a commit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_a_ff   <= RST_CODE;
      in_b_ff   <= RST_CODE;
      dac_a_ff  <= '{pd: RST_PD, code: RST_CODE};
      dac_b_ff  <= '{pd: RST_PD, code: RST_CODE};
      ext_ff    <= 1'b0;
      rd_sel_ff <= 1'b0;
    end else if (commit) begin
      if (ext_ff) begin
        ext_ff <= 1'b0;
        // pd code goes straight to the output stage
        if (cmd_ff[EXT_SEL_A]) begin
          dac_a_ff.pd <= data_ff[EXT_PD_LSB +: 2];
        end
        if (cmd_ff[EXT_SEL_B]) begin
          dac_b_ff.pd <= data_ff[EXT_PD_LSB +: 2];
        end
      end else begin
        case (cmd_code)
          CMD_LD_A: begin
            in_a_ff       <= new_val;
            dac_a_ff.code <= new_val;
            dac_b_ff.code <= in_b_ff;
          end
          CMD_LD_B: begin
            in_b_ff       <= new_val;
            dac_b_ff.code <= new_val;
            dac_a_ff.code <= in_a_ff;
          end
          CMD_IN_A: in_a_ff <= new_val;
          CMD_IN_B: in_b_ff <= new_val;
          CMD_UPD_IN_A, CMD_UPD_IN_B: begin
            dac_a_ff.code <= in_a_ff;
            dac_b_ff.code <= in_b_ff;
            if (cmd_code == CMD_UPD_IN_A) begin
              in_a_ff <= new_val;
            end else begin
              in_b_ff <= new_val;
            end
          end
          CMD_LD_ALL: begin
            in_a_ff       <= new_val;
            in_b_ff       <= new_val;
            dac_a_ff.code <= new_val;
            dac_b_ff.code <= new_val;
          end
          CMD_IN_ALL: begin
            in_a_ff <= new_val;
            in_b_ff <= new_val;
          end
          CMD_UPD: begin
            dac_a_ff.code <= in_a_ff;
            dac_b_ff.code <= in_b_ff;
          end
          CMD_EXT: begin
            case (cmd_ff[3:0])
              SUB_EXT:  ext_ff    <= 1'b1;
              SUB_RD_A: rd_sel_ff <= 1'b0;
              SUB_RD_B: rd_sel_ff <= 1'b1;
              default:  ext_ff    <= 1'b0;
            endcase
          end
          default: ext_ff <= 1'b0;
        endcase
      end
    end
  end

  // apb slave, one wait state per access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_en_ff <= RST_CTRL_EN;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
      case (paddr)
        OFS_CTRL:  prdata_ff[CTRL_EN_BIT] <= ctrl_en_ff;
        OFS_DAC_A: prdata_ff[13:0] <= {dac_a_ff.pd, 2'h0, dac_a_ff.code};
        OFS_DAC_B: prdata_ff[13:0] <= {dac_b_ff.pd, 2'h0, dac_b_ff.code};
        OFS_INPUT: prdata_ff <= {6'h0, in_b_ff, 6'h0, in_a_ff};
        OFS_STAT:  prdata_ff[3:0] <= {strap_ff, st_ff == ST_IDLE,
                                      rd_sel_ff, ext_ff};
        default:   pslverr_ff <= 1'b1;
      endcase
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      if (psel && penable && pready_ff && pwrite && paddr == OFS_CTRL) begin
        ctrl_en_ff <= pwdata[CTRL_EN_BIT];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ACK_LOW: assert property (
    st_ff == ST_SACK |-> sda_oe_ff)
    else $error("ack bit not held low");
  AST_ADDR_MATCH: assert property (
    $rose(st_ff == ST_SACK) && addr_ph_ff |-> sh_ff[7:1] == my_addr)
    else $error("acked a foreign address");
  AST_COMMIT_ONLY: assert property (
    !$stable(dac_a_ff) || !$stable(in_a_ff) |-> $past(commit))
    else $error("register changed without commit");
  AST_LD_A: assert property (
    commit && !ext_ff && cmd_code == CMD_LD_A |=>
      dac_a_ff.code == $past(new_val) && dac_b_ff.code == $past(in_b_ff))
    else $error("load a wrong");
  AST_IN_ALL: assert property (
    commit && !ext_ff && cmd_code == CMD_IN_ALL |=>
      $stable(dac_a_ff) && $stable(dac_b_ff) && in_b_ff == $past(new_val))
    else $error("input-only load wrong");
  AST_EXT_ENTER: assert property (
    commit && !ext_ff && cmd_ff == {CMD_EXT, SUB_EXT} |=> ext_ff)
    else $error("extended mode not armed");
  AST_EXT_PD: assert property (
    commit && ext_ff && cmd_ff[EXT_SEL_B] |=>
      dac_b_ff.pd == $past(data_ff[7:6]) && !ext_ff)
    else $error("power-down write wrong");
  AST_GATED: assert property (
    st_ff == ST_IDLE && !start_ev |=> st_ff == ST_IDLE)
    else $error("left idle without start");
  AST_RD_B: assert property (
    commit && !ext_ff && cmd_ff == {CMD_EXT, SUB_RD_B} |=> rd_sel_ff)
    else $error("read select b lost");
  AST_RESET: assert property (
    $rose(rst_n) |-> dac_a_ff.pd == PD_HIGH_R && dac_b_ff.code == RST_CODE)
    else $error("bad reset state");

  COV_LD_ALL: cover property (commit && cmd_code == CMD_LD_ALL);
  COV_EXT:    cover property (commit && ext_ff);
  COV_READ2:  cover property ($rose(st_ff == ST_TX) && tx_idx_ff);
endmodule

// ### verification/ddc_i2c_mst.sv
// two-wire bus master model driving the serial port of the decoder
`timescale 1ns/100ps
module ddc_i2c_mst (
  input  wire logic clk_sys,  // system clock, paces the bus
  input  wire logic sda_in,   // resolved data line level
  output logic      scl,      // serial clock, high when idle
  output logic      sda_low   // master pulls data line low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // also serves as repeated start, from scl low
  // the slave answers about five clocks after a fall, so scl stays
  // low six clocks: its data must settle before the next rise
  task automatic start();
    tick(1);
    sda_low <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(1);
    sda_low <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // one bit of 8 clocks, 400 ns: 6 low then 2 high, sampled at the fall
  task automatic bit_x(input logic b, output logic r);
    tick(1);
    sda_low <= ~b;
    tick(5);
    scl <= 1'b1;
    tick(2);
    r = sda_in;
    scl <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // master acks the first byte, nacks the last
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~ack, r);
  endtask
endmodule

// ### verification/ddc_top_tb.sv
// self-checking bench for the dual converter command decoder
`timescale 1ns/100ps
module ddc_top_tb;
  import ddc_pkg::*;
  localparam logic [5:0] ADDR_HI = 6'h2a; // arbitrary value
  localparam logic [7:0] DEV_W   = {ADDR_HI, 1'b1, 1'b0};
  typedef struct packed {
    logic [3:0] c;
    logic [9:0] v, a, b, ia, ib;
  } ddc_row_t;

  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd32;
  logic        pready, pslverr, sda_o, sda_oe, scl, sda_low, err, ak;
  logic [7:0]  b1, b2;
  wire         sda_line = ~(sda_oe & ~sda_o) & ~sda_low;
  ddc_chan_t   dac_a, dac_b;
  int          bad_count = 0, n_compared = 0;
  ddc_row_t    rows [12] = '{
    '{4'h4, 10'h155, 10'h000, 10'h000, 10'h155, 10'h000},
    '{4'h5, 10'h2aa, 10'h000, 10'h000, 10'h155, 10'h2aa},
    '{4'h0, 10'h3ff, 10'h3ff, 10'h2aa, 10'h3ff, 10'h2aa},
    '{4'h1, 10'h001, 10'h3ff, 10'h001, 10'h3ff, 10'h001},
    '{4'h4, 10'h123, 10'h3ff, 10'h001, 10'h123, 10'h001},
    '{4'h8, 10'h200, 10'h123, 10'h001, 10'h200, 10'h001},
    '{4'h9, 10'h0f0, 10'h200, 10'h001, 10'h200, 10'h0f0},
    '{4'hd, 10'h0aa, 10'h200, 10'h001, 10'h0aa, 10'h0aa},
    '{4'he, 10'h3ff, 10'h0aa, 10'h0aa, 10'h0aa, 10'h0aa},
    '{4'hc, 10'h321, 10'h321, 10'h321, 10'h321, 10'h321},
    '{4'h3, 10'h111, 10'h321, 10'h321, 10'h321, 10'h321},
    '{4'h0, 10'h1c5, 10'h1c5, 10'h321, 10'h1c5, 10'h321}
  };

  always #25 clk_sys = ~clk_sys;

  ddc_top #(.ADDR_UPPER(ADDR_HI)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(1'b1),
    .dac_a(dac_a), .dac_b(dac_b)
  );

  ddc_i2c_mst u_mst (
    .clk_sys(clk_sys), .sda_in(sda_line), .scl(scl), .sda_low(sda_low)
  );

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd32 = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end
  endtask

  // one command word; pad bits always zero
  task automatic xfer(input logic [3:0] c, input logic [9:0] v);
    u_mst.start();
    u_mst.wr(DEV_W, ak);
    chk("addr_ack", ak, 1);
    u_mst.wr({c, v[9:6]}, ak);
    chk("b1_ack", ak, 1);
    if (c !== CMD_UPD) begin
      u_mst.wr({v[5:0], 2'b00}, ak);
      chk("b2_ack", ak, 1);
    end
    u_mst.stop();
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic chk_dac(input logic [1:0] pa, pb, input logic [9:0] a, b);
    chk("dac_a", dac_a, {pa, a});
    chk("dac_b", dac_b, {pb, b});
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk_dac(2'h3, 2'h3, 10'h0, 10'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("strap", rd32[STAT_STRAP], 1);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", err, 1);
    chk("unmapped_data", rd32, 0);
    // port switched off: address not answered
    apb(1'b1, OFS_CTRL, 32'h0);
    u_mst.start();
    u_mst.wr(DEV_W, ak);
    chk("disabled_ack", ak, 0);
    u_mst.stop();
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd32, 1);
    foreach (rows[i]) begin
      xfer(rows[i].c, rows[i].v);
      chk_dac(2'h3, 2'h3, rows[i].a, rows[i].b);
      apb(1'b0, OFS_INPUT, 32'h0);
      chk("inputs", rd32, {6'h0, rows[i].ib, 6'h0, rows[i].ia});
    end
    apb(1'b0, OFS_DAC_A, 32'h0);
    chk("dac_a_reg", rd32, {18'h0, 2'h3, 2'h0, 10'h1c5});
    // word cut short by a stop after its first byte
    u_mst.start();
    u_mst.wr(DEV_W, ak);
    u_mst.wr({CMD_LD_ALL, 4'h3}, ak);
    u_mst.stop();
    chk_dac(2'h3, 2'h3, 10'h1c5, 10'h321);
    // foreign address byte 8'h54, general call, ten-bit header: all ignored
    for (int k = 0; k < 3; k++) begin
      u_mst.start();
      u_mst.wr(k == 0 ? 8'h54 : (k == 1 ? 8'h00 : 8'hf0), ak);
      chk("no_ack", ak, 0);
      u_mst.wr({CMD_LD_ALL, 4'h0}, ak);
      chk("gated", ak, 0);
      u_mst.stop();
    end
    chk_dac(2'h3, 2'h3, 10'h1c5, 10'h321);
    // read-back of each converter through a repeated start
    for (int s = 1; s <= 2; s++) begin
      u_mst.start();
      u_mst.wr(DEV_W, ak);
      u_mst.wr({CMD_EXT, s[3:0]}, ak);
      u_mst.wr(8'h00, ak);
      u_mst.start();
      u_mst.wr(DEV_W | 8'h01, ak);
      chk("rd_addr_ack", ak, 1);
      u_mst.rd(1'b1, b1);
      u_mst.rd(1'b0, b2);
      u_mst.stop();
      chk("readback", {b1, b2},
          s == 1 ? {4'h0, 10'h1c5, 2'b00} : {4'h0, 10'h321, 2'b00});
    end
    // every power-down setting on both, then on a alone
    for (int m = 0; m <= 4; m++) begin
      xfer(CMD_EXT, {SUB_EXT, 6'h0});
      xfer(4'h0, {2'b00, (m < 4), 1'b1, m[1:0], 4'h0});
      chk_dac(m[1:0], (m < 4) ? m[1:0] : 2'h3, 10'h1c5, 10'h321);
    end
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_dac(2'h3, 2'h3, 10'h0, 10'h0);
    wrap_up();
  end
endmodule
